/* File: nvm_command_object_interface.sv */
// Register front end of the flash controller: command object array,
// launch and completion, status flags, option and protection bytes.
// Assumes a command engine on the same clock and a reset sequencer
// that presents the configuration bytes with a one-cycle load pulse.
`timescale 1ns/1ns
module nvm_command_object_interface #(
  parameter int div_width = 7
) (
  // Clock and reset
  input  wire logic                          clk,
  input  wire logic                          sys_rst,
  // Register port
  input  wire logic [7:0]                    reg_addr,
  input  wire logic [7:0]                    reg_wdata,
  input  wire logic                          reg_write,
  input  wire logic                          reg_read,
  output logic      [7:0]                    reg_rdata,
  // Mode pin
  input  wire logic                          special_mode_input,
  // Configuration bytes from the reset sequence
  input  wire logic                          cfg_load,
  input  wire logic [7:0]                    cfg_option_byte,
  input  wire logic [7:0]                    cfg_dflash_byte,
  input  wire logic                          cfg_double_fault,
  // Version word from the information row
  input  wire logic [15:0]                   version_word,
  // Command engine
  output logic                               cmd_start,
  output nvm_cmd_pkg::cmd_request_type       cmd_request,
  input  wire logic                          cmd_done,
  input  wire logic                          cmd_protect_fault,
  input  wire nvm_cmd_pkg::cmd_result_type   cmd_result,
  // Status toward the rest of the controller
  output logic                               flash_timebase_tick,
  output logic                               dflash_protect_enable,
  output logic      [17:0]                   dflash_protect_last,
  output logic      [3:0]                    version_number,
  output logic                               version_valid
);

  //////////////////////////////////////////////////////////////////////
  // State

  nvm_cmd_pkg::cmd_state_type state;
  nvm_cmd_pkg::cmd_state_type next_state;

  logic [15:0]          cmd_words [6];
  logic [2:0]           command_word_index;
  logic [div_width-1:0] divider_value;
  logic                 divider_loaded_flag;
  logic [div_width-1:0] tick_count;
  logic                 access_error_flag;
  logic                 protection_violation_flag;
  logic                 dflash_protect_open;
  logic [3:0]           dflash_protect_size;
  logic [7:0]           option_bits;
  logic                 mode_meta;
  logic                 mode_special;

  //////////////////////////////////////////////////////////////////////
  // Decode

  function automatic logic is_prog_erase(input logic [7:0] code);
    case (code)
      nvm_cmd_pkg::cmd_prog_pflash,
      nvm_cmd_pkg::cmd_prog_once,
      nvm_cmd_pkg::cmd_erase_all,
      nvm_cmd_pkg::cmd_erase_block,
      nvm_cmd_pkg::cmd_erase_sector,
      nvm_cmd_pkg::cmd_unsecure,
      nvm_cmd_pkg::cmd_prog_dflash,
      nvm_cmd_pkg::cmd_erase_dsect: is_prog_erase = 1'b1;
      default:                      is_prog_erase = 1'b0;
    endcase
  endfunction

  function automatic logic special_only(input logic [7:0] code);
    special_only = (code == nvm_cmd_pkg::cmd_erase_all) ||
                   (code == nvm_cmd_pkg::cmd_unsecure) ||
                   (code == nvm_cmd_pkg::cmd_field_margin);
  endfunction

  wire logic command_complete_flag = (state == nvm_cmd_pkg::st_idle);

  wire logic wr_div    = reg_write &&
                         (reg_addr == nvm_cmd_pkg::off_clock_div);
  wire logic wr_index  = reg_write &&
                         (reg_addr == nvm_cmd_pkg::off_index);
  wire logic wr_status = reg_write &&
                         (reg_addr == nvm_cmd_pkg::off_status);
  wire logic wr_prot   = reg_write &&
                         (reg_addr == nvm_cmd_pkg::off_dflash_prot);
  wire logic wr_high   = reg_write &&
                         (reg_addr == nvm_cmd_pkg::off_cmd_high);
  wire logic wr_low    = reg_write &&
                         (reg_addr == nvm_cmd_pkg::off_cmd_low);

  wire logic obj_open  = command_complete_flag;

  wire logic launch_try = wr_status && reg_wdata[nvm_cmd_pkg::command_complete_flag_bit]
                          && command_complete_flag && !access_error_flag
                          && !protection_violation_flag;

  wire logic [7:0] command_code = cmd_words[0][15:8];

  wire logic no_divider  = is_prog_erase(command_code) &&
                           !divider_loaded_flag;
  wire logic mode_refuse = special_only(command_code) && !mode_special;
  wire logic launch_bad  = launch_try && (no_divider || mode_refuse);
  wire logic launch_ok   = launch_try && !no_divider && !mode_refuse;

  always_comb begin
    next_state = state;
    case (state)
      nvm_cmd_pkg::st_idle: begin
        if (launch_ok) begin
          next_state = nvm_cmd_pkg::st_busy;
        end
      end
      nvm_cmd_pkg::st_busy: begin
        if (cmd_done) begin
          next_state = nvm_cmd_pkg::st_idle;
        end
      end
      default: next_state = nvm_cmd_pkg::st_idle;
    endcase
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state     <= nvm_cmd_pkg::st_idle;
      cmd_start <= 1'b0;
    end else begin
      state     <= next_state;
      cmd_start <= launch_ok;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Command object array

  wire logic index_valid =
    (command_word_index <= nvm_cmd_pkg::last_word_index);

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      command_word_index <= nvm_cmd_pkg::index_reset;
    end else if (wr_index && obj_open) begin
      command_word_index <= reg_wdata[2:0];
    end
  end

  genvar w;
  generate
    for (w = 0; w < 6; w++) begin : g_word
      wire logic sel = obj_open && index_valid &&
                       (command_word_index == 3'(w));
      always_ff @(posedge clk) begin
        if (sys_rst) begin
          cmd_words[w] <= 16'h0000;
        end else if (state == nvm_cmd_pkg::st_busy && cmd_done &&
                     cmd_result.load) begin
          cmd_words[w] <= cmd_result.words[w];
        end else if (sel && wr_high) begin
          cmd_words[w][15:8] <= reg_wdata;
        end else if (sel && wr_low) begin
          if (w == 0) begin
            cmd_words[w][7:0] <= {6'h00, reg_wdata[1:0]};
          end else begin
            cmd_words[w][7:0] <= reg_wdata;
          end
        end
      end
    end
  endgenerate

  assign cmd_request.code    = command_code;
  assign cmd_request.address = {cmd_words[0][1:0], cmd_words[1]};
  assign cmd_request.data    = {cmd_words[5], cmd_words[4],
                                cmd_words[3], cmd_words[2]};

  wire logic [15:0] word_read =
    index_valid ? cmd_words[command_word_index] : 16'h0000;

  //////////////////////////////////////////////////////////////////////
  // Status flags

  // Set wins over a clear in the same cycle
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      access_error_flag         <= 1'b0;
      protection_violation_flag <= 1'b0;
    end else begin
      if (launch_bad) begin
        access_error_flag <= 1'b1;
      end else if (wr_status && reg_wdata[nvm_cmd_pkg::access_error_flag_bit]) begin
        access_error_flag <= 1'b0;
      end
      if (state == nvm_cmd_pkg::st_busy && cmd_protect_fault) begin
        protection_violation_flag <= 1'b1;
      end else if (wr_status && reg_wdata[nvm_cmd_pkg::protection_violation_flag_bit]) begin
        protection_violation_flag <= 1'b0;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Clock divider and timebase

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      divider_value       <= div_width'(nvm_cmd_pkg::div_reset);
      divider_loaded_flag <= 1'b0;
    end else if (wr_div) begin
      divider_value       <= reg_wdata[div_width-1:0];
      divider_loaded_flag <= 1'b1;
    end
  end

  // No ticks until software has set the rate
  always_ff @(posedge clk) begin
    if (sys_rst || !divider_loaded_flag || tick_count == divider_value) begin
      tick_count <= '0;
    end else begin
      tick_count <= tick_count + 1'b1;
    end
  end

  assign flash_timebase_tick = divider_loaded_flag &&
                               (tick_count == divider_value);

  //////////////////////////////////////////////////////////////////////
  // Mode pin and reset-loaded bytes

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      mode_meta    <= 1'b0;
      mode_special <= 1'b0;
    end else begin
      mode_meta    <= special_mode_input;
      mode_special <= mode_meta;
    end
  end

  wire logic [3:0] dps_new   = reg_wdata[3:0];
  wire logic       open_new  = reg_wdata[nvm_cmd_pkg::prot_open_bit];
  wire logic       dps_grows = dps_new > dflash_protect_size;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      option_bits         <= nvm_cmd_pkg::option_reset;
      dflash_protect_open <= 1'b0;
      dflash_protect_size <= nvm_cmd_pkg::dps_fault;
    end else if (cfg_load) begin
      if (cfg_double_fault) begin
        option_bits         <= nvm_cmd_pkg::option_fault;
        dflash_protect_open <= 1'b0;
        dflash_protect_size <= nvm_cmd_pkg::dps_fault;
      end else begin
        option_bits         <= cfg_option_byte;
        dflash_protect_open <= cfg_dflash_byte[nvm_cmd_pkg::prot_open_bit];
        dflash_protect_size <= cfg_dflash_byte[3:0];
      end
    end else if (wr_prot) begin
      if (mode_special) begin
        dflash_protect_open <= open_new;
        dflash_protect_size <= dps_new;
      end else begin
        if (!open_new) begin
          dflash_protect_open <= 1'b0;
        end
        if (dps_grows) begin
          dflash_protect_size <= dps_new;
        end
      end
    end
  end

  assign dflash_protect_enable = !dflash_protect_open;
  assign dflash_protect_last = nvm_cmd_pkg::dflash_base +
                               {6'h00, dflash_protect_size, 8'hff};

  assign version_number = version_word[3:0];
  assign version_valid  = (version_word[3:0] != nvm_cmd_pkg::ver_none_low)
                       && (version_word[3:0] != nvm_cmd_pkg::ver_none_high);

  //////////////////////////////////////////////////////////////////////
  // Read path

  logic [7:0] next_rdata;

  always_comb begin
    next_rdata = 8'h00;
    case (reg_addr)
      nvm_cmd_pkg::off_clock_div:
        next_rdata = {divider_loaded_flag,
                      (7)'(divider_value)};
      nvm_cmd_pkg::off_index:
        next_rdata = {5'h00, command_word_index};
      nvm_cmd_pkg::off_status:
        next_rdata = {command_complete_flag, 1'b0, access_error_flag,
                      protection_violation_flag, 4'h0};
      nvm_cmd_pkg::off_dflash_prot:
        next_rdata = {dflash_protect_open, 3'h0, dflash_protect_size};
      nvm_cmd_pkg::off_cmd_high:
        next_rdata = word_read[15:8];
      nvm_cmd_pkg::off_cmd_low:
        next_rdata = word_read[7:0];
      nvm_cmd_pkg::off_option:
        next_rdata = option_bits;
      nvm_cmd_pkg::off_mode:
        next_rdata = {7'h00, mode_special};
      default:
        next_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      reg_rdata <= 8'h00;
    end else if (reg_read) begin
      reg_rdata <= next_rdata;
    end else begin
      reg_rdata <= 8'h00;
    end
  end

endmodule

/* File: nvm_cmd_pkg.sv */
// Constants, types and register map of the flash command front end.
// Assumes an 8-bit register port and one bus clock domain.
package nvm_cmd_pkg;

  // Register offsets
  localparam logic [7:0] off_clock_div   = 8'h00;
  localparam logic [7:0] off_index       = 8'h01;
  localparam logic [7:0] off_status      = 8'h02;
  localparam logic [7:0] off_dflash_prot = 8'h03;
  localparam logic [7:0] off_cmd_high    = 8'h04;
  localparam logic [7:0] off_cmd_low     = 8'h05;
  localparam logic [7:0] off_rsv_first   = 8'h06;
  localparam logic [7:0] off_rsv_last    = 8'h09;
  localparam logic [7:0] off_option      = 8'h0a;
  localparam logic [7:0] off_rsv5        = 8'h0b;
  localparam logic [7:0] off_rsv_end     = 8'h0d;
  localparam logic [7:0] off_mode        = 8'h0e;

  // Field positions
  localparam int div_loaded_bit  = 7;
  localparam int command_complete_flag_bit        = 7;
  localparam int access_error_flag_bit      = 5;
  localparam int protection_violation_flag_bit      = 4;
  localparam int prot_open_bit   = 7;

  // Reset and fault values
  localparam logic [7:0] option_reset    = 8'hff;
  localparam logic [7:0] option_fault    = 8'hff;
  localparam logic [3:0] dps_fault       = 4'hf;
  localparam logic [6:0] div_reset       = 7'h00;
  localparam logic [2:0] index_reset     = 3'h0;
  localparam logic [2:0] last_word_index = 3'h5;

  // Data flash protection window
  localparam logic [17:0] dflash_base = 18'h04400;

  // Version word
  localparam logic [3:0] ver_none_low  = 4'h0;
  localparam logic [3:0] ver_none_high = 4'hf;

  // Commands refused in normal mode
  localparam logic [7:0] cmd_erase_all    = 8'h08;
  localparam logic [7:0] cmd_unsecure     = 8'h0b;
  localparam logic [7:0] cmd_field_margin = 8'h0e;
  // Program and erase commands
  localparam logic [7:0] cmd_prog_pflash  = 8'h06;
  localparam logic [7:0] cmd_prog_once    = 8'h07;
  localparam logic [7:0] cmd_erase_block  = 8'h09;
  localparam logic [7:0] cmd_erase_sector = 8'h0a;
  localparam logic [7:0] cmd_prog_dflash  = 8'h11;
  localparam logic [7:0] cmd_erase_dsect  = 8'h12;

  typedef enum logic {
    st_idle = 1'b0,
    st_busy = 1'b1
  } cmd_state_type;

  typedef struct packed {
    logic [7:0]       code;
    logic [17:0]      address;
    logic [3:0][15:0] data;
  } cmd_request_type;

  typedef struct packed {
    logic             load;
    logic [5:0][15:0] words;
  } cmd_result_type;

endpackage

/* File: nvm_cmd_checker.sv */
// Timing and decode checks for the flash command front end.
// Assumes binding to the top module and sight of its ports only.
`timescale 1ns/1ns
module nvm_cmd_checker (
  // Clock and reset
  input wire logic                         clk,
  input wire logic                         sys_rst,
  // Register port
  input wire logic [7:0]                   reg_addr,
  input wire logic [7:0]                   reg_wdata,
  input wire logic                         reg_write,
  input wire logic                         reg_read,
  input wire logic [7:0]                   reg_rdata,
  // Engine and status
  input wire logic                         cmd_start,
  input wire logic                         cmd_done,
  input wire nvm_cmd_pkg::cmd_request_type cmd_request,
  input wire logic [17:0]                  dflash_protect_last,
  input wire logic [15:0]                  version_word,
  input wire logic [3:0]                   version_number,
  input wire logic                         version_valid
);
  logic busy;
  wire  rd_status;
  wire  rd_rsv;
  ////////////////////////////////////////////////////////////////////////
  // Engine busy seen from outside: start pulse until done
  always_ff @(posedge clk) begin
    if (sys_rst)
      busy <= 1'b0;
    else if (cmd_start)
      busy <= 1'b1;
    else if (cmd_done)
      busy <= 1'b0;
  end
  assign rd_status = reg_read && reg_addr == nvm_cmd_pkg::off_status;
  assign rd_rsv = reg_read && ((reg_addr >= 8'h06 && reg_addr <= 8'h09)
                  || (reg_addr >= 8'h0b && reg_addr <= 8'h0d));
  ////////////////////////////////////////////////////////////////////////
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  a_start_has_cause: assert property (cmd_start |-> $past(reg_write &&
    reg_addr == nvm_cmd_pkg::off_status && reg_wdata[7]))
    else $error("start without launch write");
  a_start_one_cycle: assert property (cmd_start |=> !cmd_start)
    else $error("start pulse too long");
  a_no_restart_busy: assert property (busy |-> !cmd_start)
    else $error("start while busy");
  a_words_locked: assert property (busy |-> $stable(cmd_request))
    else $error("request changed while busy");
  a_flag_clear_busy: assert property ($past(rd_status && busy && !cmd_done)
    |-> !reg_rdata[7])
    else $error("complete flag set while busy");
  a_reserved_read_zero: assert property ($past(rd_rsv) |->
    reg_rdata == 8'h00)
    else $error("reserved read not zero");
  a_prot_window: assert property (dflash_protect_last[7:0] == 8'hff &&
    dflash_protect_last inside {[18'h044ff:18'h053ff]})
    else $error("protection end out of range");
  a_version_map: assert property (version_number == version_word[3:0] &&
    version_valid == !(version_word[3:0] inside {4'h0, 4'hf}))
    else $error("version decode wrong");
  c_launch: cover property (cmd_start);
  c_done: cover property (busy && cmd_done);
  c_rsv: cover property (rd_rsv);
endmodule
bind nvm_command_object_interface nvm_cmd_checker u_nvm_cmd_checker (
  .clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
  .reg_rdata(reg_rdata), .cmd_start(cmd_start), .cmd_done(cmd_done),
  .cmd_request(cmd_request), .dflash_protect_last(dflash_protect_last),
  .version_word(version_word), .version_number(version_number),
  .version_valid(version_valid));

/* File: nvm_command_object_interface_test.sv */
// Self-checking bench for the flash command front end.
// Assumes the package and checker are compiled first.
`timescale 1ns/1ns
module nvm_command_object_interface_test;
  logic        clk, sys_rst, reg_write, reg_read, cfg_load, cmd_start;
  logic        special_mode_input, cfg_double_fault, cmd_done;
  logic        cmd_protect_fault, flash_timebase_tick;
  logic        dflash_protect_enable, version_valid;
  logic [7:0]  reg_addr, reg_wdata, reg_rdata, rd_val, h;
  logic [7:0]  cfg_option_byte, cfg_dflash_byte;
  logic [15:0] version_word;
  logic [17:0] dflash_protect_last;
  logic [3:0]  version_number;
  logic [31:0] seed = 32'h6318;
  logic [31:0] r;
  logic [15:0] words [6];
  int          num_errors = 0;
  int          checked = 0;
  int          n;
  nvm_cmd_pkg::cmd_request_type cmd_request;
  nvm_cmd_pkg::cmd_result_type  cmd_result;

  nvm_command_object_interface u_nvm_command_object_interface (
    .clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
    .reg_rdata(reg_rdata), .special_mode_input(special_mode_input),
    .cfg_load(cfg_load), .cfg_option_byte(cfg_option_byte),
    .cfg_dflash_byte(cfg_dflash_byte), .cfg_double_fault(cfg_double_fault),
    .version_word(version_word), .cmd_start(cmd_start),
    .cmd_request(cmd_request), .cmd_done(cmd_done),
    .cmd_protect_fault(cmd_protect_fault), .cmd_result(cmd_result),
    .flash_timebase_tick(flash_timebase_tick),
    .dflash_protect_enable(dflash_protect_enable),
    .dflash_protect_last(dflash_protect_last),
    .version_number(version_number), .version_valid(version_valid));
  ////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function automatic logic [17:0] plast(logic [3:0] k);
    return 18'h04400 + {6'h00, k, 8'hff};
  endfunction
  task automatic chk(string n, logic [17:0] e, logic [17:0] g);
    checked++;
    if (g !== e) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(logic [7:0] a, logic [7:0] d);
    @(posedge clk);
    reg_write <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_write <= 1'b0;
  endtask
  // Read data lives only in the cycle after the strobe
  task automatic rd(logic [7:0] a);
    @(posedge clk);
    reg_read <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_read <= 1'b0;
    #1 rd_val = reg_rdata;
  endtask
  task automatic rdchk(string n, logic [7:0] a, logic [7:0] e);
    rd(a);
    chk(n, e, rd_val);
  endtask
  task automatic cfg(logic [7:0] o, logic [7:0] d, logic f);
    @(posedge clk);
    cfg_load         <= 1'b1;
    cfg_option_byte  <= o;
    cfg_dflash_byte  <= d;
    cfg_double_fault <= f;
    @(posedge clk);
    cfg_load <= 1'b0;
  endtask
  task automatic mode(logic m);
    special_mode_input <= m;
    repeat (4) @(posedge clk);
    rd(nvm_cmd_pkg::off_mode);
    chk("mode", m, rd_val[0]);
  endtask
  task automatic words_back();
    for (int i = 0; i < 6; i++) begin
      wr(nvm_cmd_pkg::off_index, 8'(i));
      rd(nvm_cmd_pkg::off_cmd_high);
      h = rd_val;
      rd(nvm_cmd_pkg::off_cmd_low);
      chk("word", words[i], {h, rd_val});
    end
  endtask
  task automatic close_out();
    $display("checks %0d errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  // bus clock 100 MHz, well above the floor
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Whole run needs well under a thousand cycles
  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    close_out();
  end
  initial begin
    {reg_write, reg_read, cfg_load, cfg_double_fault, cmd_done} = '0;
    {reg_addr, reg_wdata, cfg_option_byte, cfg_dflash_byte} = '0;
    {special_mode_input, cmd_protect_fault, version_word} = '0;
    cmd_result = '0;
    sys_rst = 1'b1;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    rdchk("divider", nvm_cmd_pkg::off_clock_div, 8'h00);
    rdchk("status", nvm_cmd_pkg::off_status, 8'h80);
    rdchk("unmapped", 8'h40, 8'h00);
    for (int a = 6; a < 14; a++) begin
      r = xs();
      if (a != 10) wr(8'(a), r[7:0]);
      if (a != 10) rdchk("reserved", 8'(a), 8'h00);
    end
    r = xs();
    cfg(r[7:0], 8'h80, 1'b0);
    wr(nvm_cmd_pkg::off_option, ~r[7:0]);
    rdchk("option", nvm_cmd_pkg::off_option, r[7:0]);
    cfg(8'h00, 8'h80, 1'b1);
    rdchk("option", nvm_cmd_pkg::off_option, 8'hff);
    rdchk("prot", nvm_cmd_pkg::off_dflash_prot, 8'h0f);
    mode(1'b1);
    for (int k = 0; k < 16; k++) begin
      wr(nvm_cmd_pkg::off_dflash_prot, 8'(k));
      #1;
      chk("prot_last", plast(4'(k)), dflash_protect_last);
      chk("prot_on", 1, dflash_protect_enable);
    end
    wr(nvm_cmd_pkg::off_dflash_prot, 8'h80);
    #1 chk("prot_on", 0, dflash_protect_enable);
    mode(1'b0);
    wr(nvm_cmd_pkg::off_dflash_prot, 8'h05);
    wr(nvm_cmd_pkg::off_dflash_prot, 8'h03);
    wr(nvm_cmd_pkg::off_dflash_prot, 8'h85);
    rdchk("prot", nvm_cmd_pkg::off_dflash_prot, 8'h05);
    chk("prot_last", plast(4'h5), dflash_protect_last);
    // Launch refusals: unloaded divider, then special-only command
    wr(nvm_cmd_pkg::off_cmd_high, nvm_cmd_pkg::cmd_prog_pflash);
    wr(nvm_cmd_pkg::off_status, 8'h80);
    #1 chk("start", 0, cmd_start);
    rdchk("status", nvm_cmd_pkg::off_status, 8'ha0);
    wr(nvm_cmd_pkg::off_status, 8'h20);
    r = xs();
    wr(nvm_cmd_pkg::off_clock_div, {1'b0, r[6:0]});
    rdchk("divider", nvm_cmd_pkg::off_clock_div, {1'b1, r[6:0]});
    // Timebase period is divider plus one
    @(posedge clk iff flash_timebase_tick);
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (!flash_timebase_tick && n < 300);
    chk("tick", 18'(r[6:0]) + 18'h1, 18'(n));
    wr(nvm_cmd_pkg::off_cmd_high, nvm_cmd_pkg::cmd_erase_all);
    wr(nvm_cmd_pkg::off_status, 8'h80);
    rdchk("status", nvm_cmd_pkg::off_status, 8'ha0);
    wr(nvm_cmd_pkg::off_status, 8'h20);
    for (int i = 0; i < 8; i++) begin
      r = xs();
      wr(nvm_cmd_pkg::off_index, 8'(i));
      // A legal code, so the launch below is accepted
      if (i == 0) r[15:8] = nvm_cmd_pkg::cmd_prog_dflash;
      wr(nvm_cmd_pkg::off_cmd_high, r[15:8]);
      wr(nvm_cmd_pkg::off_cmd_low, r[7:0]);
      if (i < 6) words[i] = r[15:0];
      if (i > 5) rdchk("unused", nvm_cmd_pkg::off_cmd_high, 8'h00);
    end
    words[0][7:2] = 6'h00;
    words_back();
    wr(nvm_cmd_pkg::off_status, 8'h80);
    #1 chk("start", 1, cmd_start);
    chk("code", words[0][15:8], cmd_request.code);
    chk("addr", {words[0][1:0], words[1]}, cmd_request.address);
    for (int i = 0; i < 4; i++)
      chk("data", words[i + 2], cmd_request.data[i]);
    rdchk("status", nvm_cmd_pkg::off_status, 8'h00);
    wr(nvm_cmd_pkg::off_cmd_high, ~words[5][15:8]);
    rdchk("locked", nvm_cmd_pkg::off_cmd_high, words[5][15:8]);
    wr(nvm_cmd_pkg::off_status, 8'h80);
    #1 chk("start", 0, cmd_start);
    for (int i = 1; i < 6; i++) begin
      r = xs();
      words[i] = r[15:0];
    end
    // the two writes above are the only ones while busy
    @(posedge clk);
    cmd_done   <= 1'b1;
    cmd_protect_fault <= 1'b1;
    cmd_result <= {1'b1, words[5], words[4], words[3], words[2], words[1],
                   words[0]};
    @(posedge clk);
    cmd_done <= 1'b0;
    cmd_protect_fault <= 1'b0;
    rdchk("status", nvm_cmd_pkg::off_status, 8'h90);
    wr(nvm_cmd_pkg::off_status, 8'h10);
    rdchk("status", nvm_cmd_pkg::off_status, 8'h80);
    words_back();
    for (int i = 0; i < 8; i++) begin
      r = xs();
      version_word <= (i < 2) ? {r[15:4], {4{i[0]}}} : r[15:0];
      repeat (2) @(posedge clk);
      chk("vnum", version_word[3:0], version_number);
      chk("vok", (i > 1) && !(r[3:0] inside {4'h0, 4'hf}),
          version_valid);
    end
    close_out();
  end
endmodule
